// *** common/icc_defines.vh ***
/*
 constants of the input capture channel: register byte offsets, field
 positions, reset values and mode codes.
 assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH

// register byte offsets
`define ICC_ADR_CTRL 5'h00
`define ICC_ADR_BUF 5'h04
`define ICC_ADR_STAT 5'h08
`define ICC_ADR_MASK 5'h0C

// capture_control field positions
`define ICC_MODE_LSB 0
`define ICC_MODE_MSB 2
`define ICC_NE_BIT 3
`define ICC_OV_BIT 4
`define ICC_ICI_LSB 5
`define ICC_ICI_MSB 6
`define ICC_TSEL_BIT 7
`define ICC_SIDL_BIT 13

// capture_mode codes
`define ICC_M_OFF 3'h0
`define ICC_M_BOTH 3'h1
`define ICC_M_FALL 3'h2
`define ICC_M_RISE 3'h3
`define ICC_M_RISE4 3'h4
`define ICC_M_RISE16 3'h5
`define ICC_M_UNUSED 3'h6
`define ICC_M_WAKE 3'h7

// prescaler terminal counts
`define ICC_PRE4_LAST 4'h3
`define ICC_PRE16_LAST 4'hF

// interrupt status bit positions
`define ICC_ST_CAP 0
`define ICC_ST_OVF 1
`define ICC_ST_WAKE 2

// reset values
`define ICC_CTRL_RST 16'h0000
`define ICC_MASK_RST 3'h0
`define ICC_STAT_RST 3'h0

`endif

// *** dv/icc_pin_model.sv ***
/*
 external event source on the capture pin.
 assumes the bench clock; each pulse is three clocks high, four low.
*/
`timescale 1ns/1ns
module icc_pin_model (
   input wire clk_sys,
   output reg capture_pin
);
   initial capture_pin = 1'b0;
   // n clean pulses, then settle time for the pipeline
   task pulse(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(posedge clk_sys);
            capture_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            capture_pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
         end
         repeat (3) @(posedge clk_sys);
      end
   endtask
endmodule

// *** dv/icc_top_assertions.sv ***
/*
 port checker of the capture channel.
 assumes one clk_sys domain and the asynchronous rst.
*/
`timescale 1ns/1ns
module icc_checker #(
   parameter DATA_W = 16
) (
   input wire clk_sys,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [4:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire capture_pin,
   input wire irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   chk_ctrl_unimpl: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 5'h00 |-> (wb_dat_o & 32'hFFFF_DF00) == 0)
      else $error("unimplemented bits set");
   chk_ovf_needs_data: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 5'h00 && !wb_dat_o[3] |-> !wb_dat_o[4])
      else $error("overflow with empty buffer");
   chk_unmapped_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 5'h10 |-> wb_dat_o == 0)
      else $error("unmapped read not zero");
   chk_irq_cause: assert property (
      (!wb_cyc_i && $stable(capture_pin))[*6] |=> !$rose(irq))
      else $error("irq without event");
endmodule
bind icc_top icc_checker #(.DATA_W(DATA_W)) icc_checker_i (.clk_sys, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .capture_pin, .irq);

// *** dv/input_capture_channel_test.sv ***
/*
 testbench of the capture channel over classic wishbone.
 assumes the pin model drives capture_pin; timers held steady.
*/
`timescale 1ns/1ns
module input_capture_channel_test;
   reg clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, cpu_idle, cpu_sleep;
   reg [4:0] wb_adr_i;
   reg [3:0] wb_sel_i, sel_v;
   reg [31:0] wb_dat_i, q;
   reg [15:0] timer_a_count, timer_b_count;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, capture_pin, irq;
   integer error_cnt, cmp_count, cyc_cnt, k, m, n;
   integer np [0:7] = '{2, 1, 3, 1, 8, 16, 2, 1};
   integer ne [0:7] = '{0, 2, 3, 1, 2, 1, 0, 0};
   icc_top icc_top_i (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capture_pin, .timer_a_count,
      .timer_b_count, .cpu_idle, .cpu_sleep, .irq);
   icc_pin_model icc_pin_model_i (.clk_sys, .capture_pin);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wb(input [4:0] a, input w, input [31:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= sel_v;
      wb_dat_i <= d;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1) @(posedge clk_sys);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task t_ctrl;
      wb(0, 0, 0);
      chk("ctrl reset", q, 0);
      wb(0, 1, 32'hFFFF_FFFF);
      wb(0, 0, 0);
      chk("ctrl bits", q, 32'h0000_20E7);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wb(0, 0, 0);
      chk("ctrl mid reset", q, 0);
      sel_v = 4'h2;
      wb(0, 1, 32'hFFFF_FFFF);
      sel_v = 4'h1;
      wb(0, 1, 32'h0000_0000);
      wb(0, 0, 0);
      chk("ctrl byte lanes", q, 32'h0000_2000);
      sel_v = 4'hF;
      wb(0, 1, 0);
      $display("ctrl test done");
   endtask
   task t_fifo;
      wb(0, 1, 32'h0000_0083);
      for (k = 0; k < 5; k = k + 1) begin
         timer_a_count <= 16'hA000 + k;
         icc_pin_model_i.pulse(1);
      end
      wb(0, 0, 0);
      chk("ctrl full", q, 32'h0000_009B);
      chk("irq masked", {31'd0, irq}, 0);
      wb(8, 0, 0);
      chk("fifo status", q, 3);
      for (k = 0; k < 4; k = k + 1) begin
         wb(4, 0, 0);
         chk("buffer", q, 32'h0000_A000 + k);
      end
      wb(0, 0, 0);
      chk("ctrl empty", q, 32'h0000_0083);
      wb(4, 0, 0);
      chk("empty pop", q, 0);
      wb(5'h10, 1, 32'hFFFF_FFFF);
      wb(5'h10, 0, 0);
      chk("unmapped", q, 0);
      wb(0, 1, 0);
      $display("fifo test done");
   endtask
   task t_modes;
      for (m = 0; m < 8; m = m + 1) begin
         timer_b_count <= 16'hC000 + m[15:0];
         wb(0, 1, m);
         icc_pin_model_i.pulse(np[m]);
         n = 0;
         for (k = 0; k < 4; k = k + 1) begin
            wb(4, 0, 0);
            if (q === {16'h0000, 16'hC000 + m[15:0]}) n = n + 1;
         end
         chk("mode captures", n, ne[m]);
         wb(0, 1, 0);
      end
      $display("mode test done");
   endtask
   task t_irq;
      wb(8, 0, 0);
      wb(12, 1, 32'h0000_0005);
      wb(0, 1, 32'h0000_0043);
      icc_pin_model_i.pulse(2);
      chk("irq early", {31'd0, irq}, 0);
      icc_pin_model_i.pulse(1);
      chk("irq third", {31'd0, irq}, 1);
      wb(8, 0, 0);
      chk("status", q, 1);
      chk("irq cleared", {31'd0, irq}, 0);
      wb(0, 1, 0);
      wb(0, 1, 32'h0000_0061);
      icc_pin_model_i.pulse(1);
      wb(8, 0, 0);
      chk("both edge irq", q, 1);
      wb(0, 1, 0);
      cpu_sleep <= 1'b1;
      wb(0, 1, 7);
      icc_pin_model_i.pulse(1);
      chk("wake irq", {31'd0, irq}, 1);
      wb(8, 0, 0);
      chk("wake status", q, 4);
      cpu_sleep <= 1'b0;
      wb(0, 1, 0);
      wb(12, 1, 0);
      $display("irq test done");
   endtask
   task t_idle;
      cpu_idle <= 1'b1;
      wb(0, 1, 32'h0000_2003);
      icc_pin_model_i.pulse(1);
      wb(0, 0, 0);
      chk("idle stop", q, 32'h0000_2003);
      wb(0, 1, 3);
      icc_pin_model_i.pulse(1);
      wb(0, 0, 0);
      chk("idle run", q, 32'h0000_000B);
      cpu_idle <= 1'b0;
      wb(0, 1, 0);
      $display("idle test done");
   endtask
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt = error_cnt + 1;
         finish_test;
      end
   end
   initial begin
      {rst, wb_cyc_i, wb_stb_i, wb_we_i, cpu_idle, cpu_sleep} = 6'b100000;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 0;
      wb_sel_i = 4'hF;
      sel_v = 4'hF;
      timer_a_count = 16'hA000;
      timer_b_count = 16'hC000;
      {error_cnt, cmp_count, cyc_cnt} = 0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_ctrl;
      t_fifo;
      t_modes;
      t_irq;
      t_idle;
      finish_test;
   end
endmodule

// *** rtl/icc_fifo_mem.v ***
/*
 small capture buffer memory: one write port, one read port with
 registered read data.
 assumes the caller keeps its own pointers and never writes when full.
*/
`timescale 1ns/1ns
module icc_fifo_mem #(
   parameter WIDTH = 16,
   parameter ADDR_W = 2
) (
   input wire clk_sys,
   input wire rst,
   input wire wr_en,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   input wire rd_en,
   input wire [ADDR_W-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   // storage, no reset needed
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read data
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_data <= {WIDTH{1'b0}};
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// *** rtl/icc_top.v ***
/*
 input capture channel: edge detection on the capture pin, prescaler,
 timebase selection, four-entry capture buffer, interrupt grouping,
 wake-only mode and a classic wishbone register slave.
 assumes timer counts are on clk_sys; capture_pin is asynchronous;
 cpu_idle and cpu_sleep are synchronous levels from the power controller.
*/
// The implementer's own choices: the register offsets and the Wishbone slave port.
// Notes on behaviour
// - qualifying pin event latches selected timer count
// - four-entry buffer of captures read in turn
// - idle-stop bit halts channel while cpu idle
// - timebase select one picks timer a, zero b
// - captures per interrupt: one to four
// - read-only overflow flag, hardware cleared
// - read-only not-empty flag while buffer holds data
// - mode 111 wakes on rising edge only
// - mode 110 leaves channel disabled
// - mode 101 every sixteenth, 100 every fourth rise
// - mode 011 every rise, 010 every fall
// - mode 001 both edges, irq every capture
// - mode 000 turns channel off
// - unimplemented bits read zero; reset all zero
`timescale 1ns/1ns
`include "icc_defines.vh"
module icc_top #(
   parameter DATA_W = 16,
   parameter DEPTH_LOG2 = 2
) (
   input wire clk_sys,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [4:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire capture_pin,
   input wire [DATA_W-1:0] timer_a_count,
   input wire [DATA_W-1:0] timer_b_count,
   input wire cpu_idle,
   input wire cpu_sleep,
   output wire irq
);
   localparam [DEPTH_LOG2:0] FULL_CNT = {1'b1, {DEPTH_LOG2{1'b0}}};
   localparam [DEPTH_LOG2:0] ONE_CNT = {{DEPTH_LOG2{1'b0}}, 1'b1};
   localparam [15:0] CTRL_RST = `ICC_CTRL_RST;

   // pin synchroniser and filtered level
   reg pin_s1_reg;
   reg pin_s2_reg;
   reg pin_s3_reg;
   reg pin_lvl_reg;
   wire pin_agree = (pin_s2_reg == pin_s3_reg);
   wire rise = pin_agree & pin_s2_reg & ~pin_lvl_reg;
   wire fall = pin_agree & ~pin_s2_reg & pin_lvl_reg;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
         pin_lvl_reg <= 1'b0;
      end else begin
         pin_s1_reg <= capture_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         if (pin_agree) begin
            pin_lvl_reg <= pin_s2_reg;
         end
      end
   end

   // control fields
   reg [2:0] mode_reg;
   reg [1:0] ici_reg;
   reg tsel_reg;
   reg sidl_reg;
   reg ovf_reg;
   reg [2:0] mask_reg;
   wire [2:0] stat_reg;

   // buffer pointers
   reg [DEPTH_LOG2-1:0] wr_ptr_reg;
   reg [DEPTH_LOG2-1:0] rd_ptr_reg;
   reg [DEPTH_LOG2:0] count_reg;
   wire buf_empty = (count_reg == {(DEPTH_LOG2+1){1'b0}});
   wire buf_full = (count_reg == FULL_CNT);

   // bus request decode
   reg ack_reg;
   reg [31:0] dat_reg;
   reg buf_rd_reg;
   wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire wr_req = req & wb_we_i;
   wire rd_req = req & ~wb_we_i;
   wire hit_ctrl = (wb_adr_i == `ICC_ADR_CTRL);
   wire hit_buf = (wb_adr_i == `ICC_ADR_BUF);
   wire hit_stat = (wb_adr_i == `ICC_ADR_STAT);
   wire hit_mask = (wb_adr_i == `ICC_ADR_MASK);
   wire ctrl_wr_lo = wr_req & hit_ctrl & wb_sel_i[0];
   wire ctrl_wr_hi = wr_req & hit_ctrl & wb_sel_i[1];
   wire pop = rd_req & hit_buf & ~buf_empty;
   wire [2:0] mode_new = wb_dat_i[`ICC_MODE_MSB:`ICC_MODE_LSB];
   wire mode_change = ctrl_wr_lo & (mode_new != mode_reg);

   // channel runs unless stopped in idle or clocks are gone in sleep
   wire halted = (sidl_reg & cpu_idle) | cpu_sleep;
   wire mode_cap = (mode_reg == `ICC_M_BOTH) | (mode_reg == `ICC_M_FALL) |
      (mode_reg == `ICC_M_RISE) | (mode_reg == `ICC_M_RISE4) |
      (mode_reg == `ICC_M_RISE16);
   wire active = mode_cap & ~halted;

   // prescaler for every fourth and every sixteenth rising edge
   reg [3:0] pre_reg;
   reg [3:0] pre_next;
   reg cap_evt;
   always @* begin
      cap_evt = 1'b0;
      pre_next = pre_reg;
      if (active) begin
         case (mode_reg)
            `ICC_M_BOTH: cap_evt = rise | fall;
            `ICC_M_FALL: cap_evt = fall;
            `ICC_M_RISE: cap_evt = rise;
            `ICC_M_RISE4: begin
               if (rise) begin
                  cap_evt = (pre_reg == `ICC_PRE4_LAST);
                  pre_next = cap_evt ? 4'h0 : pre_reg + 4'h1;
               end
            end
            `ICC_M_RISE16: begin
               if (rise) begin
                  cap_evt = (pre_reg == `ICC_PRE16_LAST);
                  pre_next = pre_reg + 4'h1;
               end
            end
            default: cap_evt = 1'b0;
         endcase
      end
   end

   // selected timebase
   wire [DATA_W-1:0] cap_val = tsel_reg ? timer_a_count : timer_b_count;
   wire push = cap_evt & ~buf_full;
   wire ovf_evt = cap_evt & buf_full;

   // captures per interrupt
   reg [1:0] grp_reg;
   wire grp_done = (mode_reg == `ICC_M_BOTH) | (grp_reg == ici_reg);
   wire cap_irq_evt = cap_evt & grp_done;

   // wake-only mode, rising edge during sleep or idle
   wire wake_evt = (mode_reg == `ICC_M_WAKE) & rise & (cpu_sleep | cpu_idle);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_reg <= 4'h0;
         grp_reg <= 2'h0;
      end else if (mode_change) begin
         pre_reg <= 4'h0;
         grp_reg <= 2'h0;
      end else begin
         pre_reg <= pre_next;
         if (cap_evt) begin
            grp_reg <= grp_done ? 2'h0 : grp_reg + 2'h1;
         end
      end
   end

   // control register and overflow flag
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_reg <= CTRL_RST[`ICC_MODE_MSB:`ICC_MODE_LSB];
         ici_reg <= CTRL_RST[`ICC_ICI_MSB:`ICC_ICI_LSB];
         tsel_reg <= CTRL_RST[`ICC_TSEL_BIT];
         sidl_reg <= CTRL_RST[`ICC_SIDL_BIT];
         ovf_reg <= CTRL_RST[`ICC_OV_BIT];
      end else begin
         if (ctrl_wr_lo) begin
            mode_reg <= mode_new;
            ici_reg <= wb_dat_i[`ICC_ICI_MSB:`ICC_ICI_LSB];
            tsel_reg <= wb_dat_i[`ICC_TSEL_BIT];
         end
         if (ctrl_wr_hi) begin
            sidl_reg <= wb_dat_i[`ICC_SIDL_BIT];
         end
         if (ovf_evt) begin
            ovf_reg <= 1'b1;
         end else if ((pop & (count_reg == ONE_CNT)) |
               (ctrl_wr_lo & (mode_new == `ICC_M_OFF))) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // buffer pointers; turning the channel off flushes it
   wire flush = ctrl_wr_lo & (mode_new == `ICC_M_OFF);
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= {DEPTH_LOG2{1'b0}};
         rd_ptr_reg <= {DEPTH_LOG2{1'b0}};
         count_reg <= {(DEPTH_LOG2+1){1'b0}};
      end else if (flush) begin
         wr_ptr_reg <= {DEPTH_LOG2{1'b0}};
         rd_ptr_reg <= {DEPTH_LOG2{1'b0}};
         count_reg <= {(DEPTH_LOG2+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   wire [DATA_W-1:0] mem_rd_data;
   icc_fifo_mem #(
      .WIDTH(DATA_W),
      .ADDR_W(DEPTH_LOG2)
   ) u_mem (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr_en(push),
      .wr_addr(wr_ptr_reg),
      .wr_data(cap_val),
      .rd_en(pop),
      .rd_addr(rd_ptr_reg),
      .rd_data(mem_rd_data)
   );

   // interrupt status: set wins over the read clear
   wire [2:0] stat_set;
   assign stat_set[`ICC_ST_CAP] = cap_irq_evt;
   assign stat_set[`ICC_ST_OVF] = ovf_evt;
   assign stat_set[`ICC_ST_WAKE] = wake_evt;
   wire stat_clr = rd_req & hit_stat;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_stat
         reg bit_reg;
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               bit_reg <= 1'b0;
            end else if (stat_set[gi]) begin
               bit_reg <= 1'b1;
            end else if (stat_clr) begin
               bit_reg <= 1'b0;
            end
         end
         assign stat_reg[gi] = bit_reg;
      end
   endgenerate

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_reg <= `ICC_MASK_RST;
      end else if (wr_req & hit_mask & wb_sel_i[0]) begin
         mask_reg <= wb_dat_i[2:0];
      end
   end

   assign irq = |(stat_reg & mask_reg);

   // read data and acknowledge
   wire [15:0] ctrl_view = {2'b00, sidl_reg, 5'b0_0000, tsel_reg, ici_reg,
      ovf_reg, ~buf_empty, mode_reg};
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux = {16'h0000, ctrl_view};
      end else if (hit_stat) begin
         rd_mux = {29'h0000_0000, stat_reg};
      end else if (hit_mask) begin
         rd_mux = {29'h0000_0000, mask_reg};
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
         buf_rd_reg <= 1'b0;
      end else begin
         ack_reg <= req;
         buf_rd_reg <= pop;
         if (rd_req) begin
            dat_reg <= rd_mux;
         end else begin
            dat_reg <= 32'h0000_0000;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = buf_rd_reg ? {{(32-DATA_W){1'b0}}, mem_rd_data} : dat_reg;
endmodule
